//--- dv/rmap_read_incrementing_handler_tb.sv
// Bench joining both link ends, with a register file behind the device
`timescale 1ns/100ps
`default_nettype none
module rmap_read_incrementing_handler_tb;
	localparam logic [7:0] OK = rri_pkg::ST_OK;     // Status shorthands
	localparam logic [7:0] AC = rri_pkg::ST_ACCESS;
	logic        clk_sys = 1'b0, arst_n = 1'b0, req_valid = 1'b0;
	logic [15:0] req_tid = 16'h0000;
	logic [31:0] req_addr = 32'h0000_0000;
	logic [23:0] req_len = 24'h00_0000;
	logic [7:0]  req_key = 8'h00, req_sla = 8'h00;
	logic [1:0]  req_plen = 2'h0;
	logic [95:0] req_path = 96'h0;
	logic        req_ready, rep_valid, rep_hcrc_ok, rep_dcrc_ok, word_valid;
	logic [7:0]  rep_status;
	logic [15:0] rep_tid;
	logic [23:0] rep_len;
	logic [31:0] word_data;
	logic [8:0]  rd_addr;
	logic        dev_done;
	logic [7:0]  dev_last;
	logic [48:0] expq[$], note;   // Reply notes: status, tid, length, header check good
	logic [31:0] wq[$];           // Words still due, oldest first
	int          seed = 21, error_cnt = 0, checks = 0;
	wire logic [31:0] rd_data = {7'h00, rd_addr, 16'hC35A}; // Each register shows its address
	rri_link_if lnk (.clk_sys(clk_sys), .arst_n(arst_n));
	rri_dev rri_dev_inst (.lnk(lnk), .ce(1'b1), .key_val(rri_pkg::KEY_RESET), .rd_req(),
		.done(dev_done), .last_status(dev_last), .*);
	rri_host rri_host_inst (.lnk(lnk), .ce(1'b1), .*);
	rri_sva rri_sva_inst (.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(lnk.cmd_valid),
		.cmd_ready(lnk.cmd_ready), .cmd_eop(lnk.cmd_eop), .cmd_data(lnk.cmd_data),
		.rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready), .rsp_eop(lnk.rsp_eop),
		.rsp_data(lnk.rsp_data));
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic check(input string name, input logic [48:0] seen, input logic [48:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One request; notes go in before it leaves, then the reply is awaited
	task automatic req(input logic [31:0] a, input logic [23:0] l, input logic [7:0] k,
		input logic [7:0] st, input logic [1:0] p);
		@(posedge clk_sys);
		#1;
		while (req_ready !== 1'b1) #4;
		{req_addr, req_len, req_key, req_plen, req_valid} = {a, l, k, p, 1'b1};
		req_tid = 16'($random(seed));
		req_sla = 8'($random(seed));
		req_path = {$random(seed), $random(seed), $random(seed)};
		expq.push_back({st, req_tid, l, 1'b1});
		for (int n = 0; st === OK && n < int'(l) / 4; n++)
			wq.push_back({7'h00, 9'(a + 32'(4 * n)), 16'hC35A});
		@(posedge clk_sys);
		#1;
		req_valid = 1'b0;
		while (expq.size() != 0)
			@(posedge clk_sys);
	endtask
	// Mid-cycle sampling, so the host's one-cycle pulses have settled
	always @(negedge clk_sys) begin
		if (dev_done === 1'b1)
			check("last status", 49'(dev_last), 49'(expq[0][48:41]));
		if (word_valid === 1'b1)
			check("word", 49'(word_data), 49'(wq.pop_front()));
		if (rep_valid === 1'b1) begin
			note = expq.pop_front();
			check("reply", {rep_status, rep_tid, rep_len, rep_hcrc_ok}, note);
			if (note[48:41] === OK)
				check("data check", 49'(rep_dcrc_ok), 49'h1);
		end
	end
	// Good reads over every path length, then boundaries and refusals
	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		arst_n = 1'b1;
		for (int p = 0; p < 4; p++)
			req(32'(8 * p), 24'(4 + 12 * p), 8'h20, OK, 2'(p));
		req(32'h0108, 24'h0004, 8'h20, OK, 2'h0);
		req(32'h0000, 24'h010C, 8'h20, OK, 2'h1);
		req(32'h0000, 24'h0110, 8'h20, AC, 2'h0);
		req(32'h0000, 24'h0006, 8'h20, AC, 2'h2);
		req(32'h0000, 24'h0000, 8'h20, AC, 2'h0);
		req(32'h0000, 24'h042C, 8'h20, AC, 2'h0);
		req(32'h0002, 24'h0004, 8'h20, AC, 2'h3);
		req(32'h1_0000, 24'h0004, 8'h20, AC, 2'h0);
		req(32'h0000, 24'h0004, 8'h21, rri_pkg::ST_KEY, 2'h0);
		req(32'h0002, 24'h0006, 8'h00, rri_pkg::ST_KEY, 2'h1);
		conclude();
	end
	// Watchdog: the sequence needs about 1200 cycles, this allows far more
	initial begin
		#100000;
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire

//--- dv/rri_sva.sv
// Link checker for the read-incrementing command exchange
`timescale 1ns/100ps
`default_nettype none
module rri_sva (
	input wire logic       clk_sys,
	input wire logic       arst_n,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic       cmd_eop,
	input wire logic [7:0] cmd_data,
	input wire logic       rsp_valid,
	input wire logic       rsp_ready,
	input wire logic       rsp_eop,
	input wire logic [7:0] rsp_data
);
	logic [4:0]      cp_ff;                                   // Command byte index
	logic [4:0]      rp_ff;                                   // Reply byte index, saturating
	logic [7:0]      cb_ff;                                   // Command byte (index 3) of the latest command
	wire logic       cd = cmd_valid && cmd_ready && !cmd_eop; // Command byte taken
	wire logic       rd = rsp_valid && rsp_ready && !rsp_eop; // Reply byte taken
	wire logic [4:0] hp = {1'b0, cb_ff[1:0], 2'b00};          // Path bytes before the header
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// Indexes restart at each end marker, so a dropped packet cannot skew the next
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cp_ff <= 5'h00;
			rp_ff <= 5'h00;
			cb_ff <= 8'h00;
		end else begin
			if (cmd_valid && cmd_ready)
				cp_ff <= cmd_eop ? 5'h00 : cp_ff + 5'h01;
			if (rsp_valid && rsp_ready)
				rp_ff <= rsp_eop ? 5'h00 : rp_ff + {4'h0, rp_ff != 5'h1F};
			if (cd && cp_ff == 5'h03)
				cb_ff <= cmd_data;
		end
	end
	a_busy_excl: assert property (rsp_valid |-> !cmd_ready)
		else $error("reply while taking");
	a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
		else $error("reply byte moved");
	a_reply_start: assert property (cmd_valid && cmd_ready && cmd_eop ##1 !cmd_ready
		|-> ##[0:2] rsp_valid) else $error("no reply");
	a_type_cmd: assert property (cd && cp_ff == 5'h03 |-> cmd_data[7:2] == 6'h13)
		else $error("bad command byte");
	a_pid_reply: assert property (rd && rp_ff == hp + 5'h01 |-> rsp_data == 8'h01)
		else $error("bad reply protocol");
	a_cmd_reply: assert property (rd && rp_ff == hp + 5'h02 |-> rsp_data == {2'h0, cb_ff[5:0]})
		else $error("bad reply command");
	a_tla_reply: assert property (rd && rp_ff == hp + 5'h04 |-> rsp_data == 8'hFE)
		else $error("bad reply target");
	a_rsvd_zero: assert property (rd && rp_ff == hp + 5'h07 |-> rsp_data == 8'h00)
		else $error("reserved not zero");
	c_path_max: cover property (cd && cp_ff == 5'h03 && cmd_data[1:0] == 2'h3);
	c_cmd_end: cover property (cmd_valid && cmd_ready && cmd_eop);
	c_rsp_end: cover property (rsp_valid && rsp_ready && rsp_eop);
endmodule
`default_nettype wire

//--- hw/rri_crc8.sv
// One-byte step of the eight-bit packet check code
`timescale 1ns/100ps
`default_nettype none
module rri_crc8 (
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] data,
	output logic      [7:0] crc_out
);
	// Bits go in LSB first, so the reflected polynomial is used
	always_comb begin
		crc_out = crc_in;
		for (int i = 0; i < 8; i++) begin
			if (crc_out[0] ^ data[i]) begin
				crc_out = (crc_out >> 1) ^ rri_pkg::CRC_POLY;
			end else begin
				crc_out = crc_out >> 1;
			end
		end
	end
endmodule
`default_nettype wire

//--- hw/rri_dev.sv
// Configuration-port end: takes read-incrementing commands, returns replies
// Behaviour
// - Reject counts not multiple of four
// - Only aligned word reads up to 0x109
// - Target logical address must be FEh
// - Protocol identifier must be 01h
// - Key must match key register, 20h
// - Sender sets extended address to zero
// - Header check code verified before reading
// - Command carries 0/4/8/12 return-path bytes
// - First command byte is port 00h
// - Source address is sender's or FEh
// - Four-byte address, three-byte length, word increment
// - Reply leaves on the arrival port
// - Reply starts with path or source address
// - Reply has 01h and reply type
// - Status byte then zero reserved byte
// - Reply target address is FEh
// - Transaction identifier echoed unchanged
// - Reply length equals requested length
// - Words MS byte first, checks and EOP
`timescale 1ns/100ps
`default_nettype none
module rri_dev (
	rri_link_if.dev         lnk,
	input  wire logic       ce,
	input  wire logic [7:0] key_val,
	output logic            rd_req,
	output logic [8:0]      rd_addr,
	input  wire logic [31:0] rd_data,
	output logic            done,
	output logic [7:0]      last_status
);
	// Gray along receive, header, fetch, latch, data, tail, end
	typedef enum logic [2:0] {
		S_RX    = 3'b000,
		S_HDR   = 3'b001,
		S_FETCH = 3'b011,
		S_LATCH = 3'b010,
		S_DATA  = 3'b110,
		S_TAIL  = 3'b111,
		S_EOP   = 3'b101,
		S_DROP  = 3'b100
	} rri_dst_t;

	typedef struct packed {
		rri_dst_t        st;      // Sequencer state
		logic [4:0]      pos;     // Byte position in header
		logic [1:0]      plw;     // Return path length in words
		logic [11:0][7:0] path;   // Return path bytes
		logic [7:0]      dla;     // Target logical address seen
		logic [7:0]      pid;     // Protocol identifier seen
		logic [7:0]      cmd;     // Command byte seen
		logic [7:0]      key;     // Key seen
		logic [7:0]      sla;     // Source logical address
		logic [15:0]     tid;     // Transaction identifier
		logic [31:0]     addr;    // Next read address
		logic [23:0]     len;     // Requested byte count
		logic [7:0]      crc;     // Running check code
		logic [7:0]      status;  // Reply status
		logic [8:0]      wleft;   // Words still to fetch
		logic [1:0]      bsel;    // Byte within the current word
		logic [31:0]     word;    // Word being sent
		logic            rdy;     // Command stream ready
		logic            ov;      // Reply token valid
		logic            oe;      // Reply token is end marker
		logic [7:0]      od;      // Reply byte
		logic            rd;      // Register read strobe
		logic            done;    // Reply finished pulse
		logic [7:0]      last;    // Status of last reply
	} rri_dstate_t;

	localparam rri_dstate_t D_RST = '{st: S_RX, rdy: 1'b1, default: '0};

	rri_dstate_t q;        // Registered state
	rri_dstate_t n;        // Next state
	logic [7:0]  crc_d;    // Byte fed to the check code
	logic [7:0]  crc_o;    // Check code after that byte
	logic [7:0]  txb;      // Reply byte for this position

	rri_crc8 u_crc (
		.crc_in  (q.crc),
		.data    (crc_d),
		.crc_out (crc_o)
	);

	// One check unit serves both directions; they never overlap in time
	assign crc_d = (q.st == S_RX) ? lnk.cmd_data : txb;

	// Reply byte selection by position
	always_comb begin
		logic [4:0] roff;
		roff = q.pos - {1'b0, q.plw, 2'b00};
		txb  = 8'h00;
		if (q.st == S_DATA) begin
			txb = q.word[31:24];
		end else if (q.st == S_TAIL) begin
			txb = q.crc;
		end else if (q.pos < {1'b0, q.plw, 2'b00}) begin
			txb = q.path[q.pos[3:0]];
		end else begin
			unique case (roff)
				rri_pkg::ROFF_SLA:  txb = q.sla;
				rri_pkg::ROFF_PID:  txb = rri_pkg::PROTO_ID;
				rri_pkg::ROFF_CMD:  txb = {rri_pkg::TYPE_REPLY, q.cmd[5:0]};
				rri_pkg::ROFF_ST:   txb = q.status;
				rri_pkg::ROFF_TLA:  txb = rri_pkg::LA_DEF;
				rri_pkg::ROFF_TIDM: txb = q.tid[15:8];
				rri_pkg::ROFF_TIDL: txb = q.tid[7:0];
				rri_pkg::ROFF_RSVD: txb = rri_pkg::RSVD_BYTE;
				5'h08:              txb = q.len[23:16];
				5'h09:              txb = q.len[15:8];
				5'h0A:              txb = q.len[7:0];
				default:            txb = q.crc;
			endcase
		end
	end

	// Sequencer: receive and check, then build the reply
	always_comb begin
		logic [4:0]  plen;
		logic [4:0]  off;
		logic [4:0]  hend;
		logic [16:0] lim;
		logic        acc;
		logic        free;
		logic        acc_ok;
		plen   = {1'b0, q.plw, 2'b00};
		off    = q.pos - rri_pkg::POS_PATH - plen;
		hend   = rri_pkg::POS_PATH + plen + rri_pkg::OFF_HCRC;
		lim    = {1'b0, q.addr[15:0]} + {6'b0, q.len[10:0]} - 17'h0_0004;
		acc    = lnk.cmd_valid & q.rdy;
		free   = ~q.ov | lnk.rsp_ready;
		acc_ok = (q.addr[1:0] == 2'b00) && (q.addr[31:16] == 16'h0000)
			&& (q.len[1:0] == 2'b00)
			&& (q.len >= rri_pkg::LEN_MIN) && (q.len <= rri_pkg::LEN_MAX)
			&& (lim <= rri_pkg::ADDR_LAST);
		n      = q;
		n.done = 1'b0;
		n.rd   = 1'b0;
		// A taken token frees the output slot
		if (free) begin
			n.ov = 1'b0;
		end
		unique case (q.st)
			S_RX: begin
				// Take commands again only once the reply end marker has left
				if (!q.rdy && free) begin
					n.rdy = 1'b1;
				end
				if (acc && lnk.cmd_eop) begin
					n.pos = 5'h00;
					n.crc = rri_pkg::CRC_INIT;
					// Short packets and bad header checks get no reply at all
					if (q.pos == hend + 5'h01 && q.crc == 8'h00) begin
						n.st  = S_HDR;
						n.rdy = 1'b0;
						n.wleft = q.len[10:2];
						if (q.dla != rri_pkg::LA_DEF) begin
							n.status = rri_pkg::ST_LA;
						end else if (q.pid != rri_pkg::PROTO_ID ||
							q.cmd[7:2] != {rri_pkg::TYPE_CMD, rri_pkg::CODE_RDINC}) begin
							n.status = rri_pkg::ST_CMD;
						end else if (q.key != key_val) begin
							n.status = rri_pkg::ST_KEY;
						end else if (!acc_ok) begin
							n.status = rri_pkg::ST_ACCESS;
						end else begin
							n.status = rri_pkg::ST_OK;
						end
					end
				end else if (acc) begin
					n.pos = q.pos + 5'h01;
					// Port byte is not covered by the check code
					if (q.pos != 5'h00) begin
						n.crc = crc_o;
					end
					if (q.pos == rri_pkg::POS_DLA) begin
						n.dla = lnk.cmd_data;
					end else if (q.pos == rri_pkg::POS_PID) begin
						n.pid = lnk.cmd_data;
					end else if (q.pos == rri_pkg::POS_CMD) begin
						n.cmd = lnk.cmd_data;
						n.plw = lnk.cmd_data[1:0];
					end else if (q.pos == rri_pkg::POS_KEY) begin
						n.key = lnk.cmd_data;
					end else if (q.pos < rri_pkg::POS_PATH + plen) begin
						n.path[off + plen] = lnk.cmd_data;
					end else if (q.pos > hend) begin
						n.st = S_DROP;                                  // Overlong header
					end else begin
						unique case (off)
							rri_pkg::OFF_SLA:  n.sla = lnk.cmd_data;
							rri_pkg::OFF_TIDM: n.tid[15:8] = lnk.cmd_data;
							rri_pkg::OFF_TIDL: n.tid[7:0] = lnk.cmd_data;
							rri_pkg::OFF_EXT:  n.crc = crc_o;
							5'h04, 5'h05, 5'h06, 5'h07: n.addr = {q.addr[23:0], lnk.cmd_data};
							5'h08, 5'h09, 5'h0A: n.len = {q.len[15:0], lnk.cmd_data};
							default:           n.crc = crc_o;           // Header check byte
						endcase
					end
				end
			end
			S_HDR: begin
				if (free) begin
					n.ov  = 1'b1;
					n.oe  = 1'b0;
					n.od  = txb;
					n.pos = q.pos + 5'h01;
					if (q.pos >= plen) begin
						n.crc = crc_o;
					end
					if (q.pos == plen + rri_pkg::ROFF_HCRC) begin
						n.pos = 5'h00;
						n.crc = rri_pkg::CRC_INIT;
						if (q.status == rri_pkg::ST_OK) begin
							n.st = S_FETCH;
							n.rd = 1'b1;
						end else begin
							n.st = S_EOP;
						end
					end
				end
			end
			S_FETCH: begin
				n.st = S_LATCH;
			end
			S_LATCH: begin
				// Register data answers one cycle after the strobe
				n.word  = rd_data;
				n.addr  = q.addr + 32'h0000_0004;
				n.wleft = q.wleft - 9'h001;
				n.bsel  = 2'b00;
				n.st    = S_DATA;
			end
			S_DATA: begin
				if (free) begin
					n.ov   = 1'b1;
					n.oe   = 1'b0;
					n.od   = txb;
					n.crc  = crc_o;
					n.word = {q.word[23:0], 8'h00};
					n.bsel = q.bsel + 2'b01;
					if (q.bsel == 2'b11) begin
						if (q.wleft == 9'h000) begin
							n.st = S_TAIL;
						end else begin
							n.st = S_FETCH;
							n.rd = 1'b1;
						end
					end
				end
			end
			S_TAIL: begin
				if (free) begin
					n.ov = 1'b1;
					n.oe = 1'b0;
					n.od = txb;
					n.st = S_EOP;
				end
			end
			S_EOP: begin
				if (free) begin
					n.ov   = 1'b1;
					n.oe   = 1'b1;
					n.od   = 8'h00;
					n.st   = S_RX;
					n.done = 1'b1;
					n.last = q.status;
					n.crc  = rri_pkg::CRC_INIT;
				end
			end
			S_DROP: begin
				if (acc && lnk.cmd_eop) begin
					n.st  = S_RX;
					n.pos = 5'h00;
					n.crc = rri_pkg::CRC_INIT;
				end
			end
		endcase
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge lnk.clk_sys or negedge lnk.arst_n) begin
		if (!lnk.arst_n) begin
			q <= D_RST;
		end else if (ce) begin
			q <= n;
		end
	end

	// Outputs straight from the state register
	assign lnk.cmd_ready = q.rdy;
	assign lnk.rsp_valid = q.ov;
	assign lnk.rsp_eop   = q.oe;
	assign lnk.rsp_data  = q.od;
	assign rd_req        = q.rd;
	assign rd_addr       = q.addr[8:0];
	assign done          = q.done;
	assign last_status   = q.last;
endmodule
`default_nettype wire

//--- hw/rri_host.sv
// Command-sender end: builds read-incrementing commands and parses replies
`timescale 1ns/100ps
`default_nettype none
module rri_host (
	rri_link_if.host         lnk,
	input  wire logic        ce,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [15:0] req_tid,
	input  wire logic [31:0] req_addr,
	input  wire logic [23:0] req_len,
	input  wire logic [7:0]  req_key,
	input  wire logic [7:0]  req_sla,
	input  wire logic [1:0]  req_plen,
	input  wire logic [95:0] req_path,
	output logic             rep_valid,
	output logic [7:0]       rep_status,
	output logic [15:0]      rep_tid,
	output logic [23:0]      rep_len,
	output logic             rep_hcrc_ok,
	output logic             rep_dcrc_ok,
	output logic             word_valid,
	output logic [31:0]      word_data
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_RECV = 2'b11
	} rri_hst_t;

	typedef struct packed {
		rri_hst_t         st;     // Sequencer state
		logic [4:0]       pos;    // Header byte position
		logic [1:0]       plw;    // Path length in words
		logic [11:0][7:0] path;   // Return path bytes
		logic [7:0]       key;    // Key to send
		logic [7:0]       sla;    // Own logical address
		logic [15:0]      tid;    // Transaction identifier
		logic [31:0]      addr;   // Address, shifted out MS first
		logic [23:0]      len;    // Length, shifted out MS first
		logic [7:0]       crc;    // Running check code
		logic             rq;     // Request port ready
		logic             ov;     // Command token valid
		logic             oe;     // Command token is end marker
		logic [7:0]       od;     // Command byte
		logic             rr;     // Reply stream ready
		logic [7:0]       rst;    // Reply status
		logic [15:0]      rtid;   // Reply identifier
		logic [23:0]      rlen;   // Reply length
		logic             hok;    // Reply header check good
		logic             dok;    // Reply data check good
		logic [1:0]       nb;     // Bytes in current word
		logic [31:0]      word;   // Word being gathered
		logic             wv;     // Word pulse
		logic             rv;     // Reply pulse
	} rri_hstate_t;

	localparam rri_hstate_t H_RST = '{st: H_IDLE, rq: 1'b1, default: '0};

	rri_hstate_t q;      // Registered state
	rri_hstate_t n;      // Next state
	logic [7:0]  crc_d;  // Byte fed to the check code
	logic [7:0]  crc_o;  // Check code after it
	logic [7:0]  txb;    // Command byte for this position

	rri_crc8 u_crc (
		.crc_in  (q.crc),
		.data    (crc_d),
		.crc_out (crc_o)
	);

	assign crc_d = (q.st == H_RECV) ? lnk.rsp_data : txb;

	// Command byte selection; the user owns length, address and key validity
	always_comb begin
		logic [4:0] off;
		off = q.pos - rri_pkg::POS_PATH - {1'b0, q.plw, 2'b00};
		txb = q.crc;
		if (q.pos == 5'h00) begin
			txb = rri_pkg::CFG_PORT;
		end else if (q.pos == rri_pkg::POS_DLA) begin
			txb = rri_pkg::LA_DEF;
		end else if (q.pos == rri_pkg::POS_PID) begin
			txb = rri_pkg::PROTO_ID;
		end else if (q.pos == rri_pkg::POS_CMD) begin
			txb = {rri_pkg::TYPE_CMD, rri_pkg::CODE_RDINC, q.plw};
		end else if (q.pos == rri_pkg::POS_KEY) begin
			txb = q.key;
		end else if (q.pos < rri_pkg::POS_PATH + {1'b0, q.plw, 2'b00}) begin
			txb = q.path[q.pos[3:0] - 4'h5];
		end else if (off == rri_pkg::OFF_SLA) begin
			txb = q.sla;
		end else if (off == rri_pkg::OFF_TIDM) begin
			txb = q.tid[15:8];
		end else if (off == rri_pkg::OFF_TIDL) begin
			txb = q.tid[7:0];
		end else if (off == rri_pkg::OFF_EXT) begin
			txb = rri_pkg::EXT_ADDR;
		end else if (off < rri_pkg::OFF_LEN) begin
			txb = q.addr[31:24];
		end else if (off < rri_pkg::OFF_HCRC) begin
			txb = q.len[23:16];
		end
	end

	// Sequencer: send one command, then collect its reply
	always_comb begin
		logic [4:0] hend;
		logic [4:0] roff;
		logic       free;
		logic       acc;
		hend   = rri_pkg::POS_PATH + {1'b0, q.plw, 2'b00} + rri_pkg::OFF_HCRC;
		roff   = q.pos - {1'b0, q.plw, 2'b00};
		free   = ~q.ov | lnk.cmd_ready;
		acc    = lnk.rsp_valid & q.rr;
		n      = q;
		n.wv   = 1'b0;
		n.rv   = 1'b0;
		if (free) begin
			n.ov = 1'b0;
		end
		unique case (q.st)
			H_IDLE: begin
				if (req_valid && q.rq) begin
					n.st   = H_SEND;
					n.rq   = 1'b0;
					n.pos  = 5'h00;
					n.crc  = rri_pkg::CRC_INIT;
					n.plw  = req_plen;
					n.path = req_path;
					n.key  = req_key;
					n.sla  = req_sla;
					n.tid  = req_tid;
					n.addr = req_addr;
					n.len  = req_len;
				end
			end
			H_SEND: begin
				if (free) begin
					n.ov  = 1'b1;
					n.oe  = (q.pos > hend);
					n.od  = (q.pos > hend) ? 8'h00 : txb;
					n.pos = q.pos + 5'h01;
					if (q.pos != 5'h00) begin
						n.crc = crc_o;
					end
					if (q.pos > hend - 5'h04 && q.pos < hend - 5'h00) begin
						n.len = {q.len[15:0], 8'h00};
					end else if (q.pos > hend - 5'h08 && q.pos <= hend - 5'h04) begin
						n.addr = {q.addr[23:0], 8'h00};
					end
					if (q.pos > hend) begin
						n.st  = H_RECV;
						n.rr  = 1'b1;
						n.pos = 5'h00;
						n.crc = rri_pkg::CRC_INIT;
						n.nb  = 2'b00;
					end
				end
			end
			H_RECV: begin
				if (acc && lnk.rsp_eop) begin
					n.st  = H_IDLE;
					n.rr  = 1'b0;
					n.rq  = 1'b1;
					n.rv  = 1'b1;
					n.dok = (q.crc == 8'h00);
				end else if (acc && q.pos >= {1'b0, q.plw, 2'b00} && roff > rri_pkg::ROFF_HCRC) begin
					// Path bytes wrap roff high, so they are kept out of the data region
					// Data region; the trailing check byte leaves a zero residue
					n.crc  = crc_o;
					n.word = {q.word[23:0], lnk.rsp_data};
					n.nb   = q.nb + 2'b01;
					n.wv   = (q.nb == 2'b11);
				end else if (acc) begin
					n.pos = q.pos + 5'h01;
					if (q.pos >= {1'b0, q.plw, 2'b00}) begin
						n.crc = crc_o;
					end
					if (roff == rri_pkg::ROFF_ST) begin
						n.rst = lnk.rsp_data;
					end else if (roff == rri_pkg::ROFF_TIDM || roff == rri_pkg::ROFF_TIDL) begin
						n.rtid = {q.rtid[7:0], lnk.rsp_data};
					end else if (roff >= rri_pkg::ROFF_LEN && roff < rri_pkg::ROFF_HCRC) begin
						n.rlen = {q.rlen[15:0], lnk.rsp_data};
					end else if (roff == rri_pkg::ROFF_HCRC) begin
						n.hok = (crc_o == 8'h00);
						n.crc = rri_pkg::CRC_INIT;
					end
				end
			end
			default: n = q;
		endcase
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge lnk.clk_sys or negedge lnk.arst_n) begin
		if (!lnk.arst_n) begin
			q <= H_RST;
		end else if (ce) begin
			q <= n;
		end
	end

	assign lnk.cmd_valid = q.ov;
	assign lnk.cmd_eop   = q.oe;
	assign lnk.cmd_data  = q.od;
	assign lnk.rsp_ready = q.rr;
	assign req_ready     = q.rq;
	assign rep_valid     = q.rv;
	assign rep_status    = q.rst;
	assign rep_tid       = q.rtid;
	assign rep_len       = q.rlen;
	assign rep_hcrc_ok   = q.hok;
	assign rep_dcrc_ok   = q.dok;
	assign word_valid    = q.wv;
	assign word_data     = q.word;
endmodule
`default_nettype wire

//--- hw/rri_link_if.sv
// Byte stream link between command sender and configuration logic
`timescale 1ns/100ps
`default_nettype none
interface rri_link_if (
	input wire logic clk_sys,
	input wire logic arst_n
);
	logic       cmd_valid;  // Command byte or end marker offered
	logic       cmd_ready;  // Configuration logic takes it
	logic       cmd_eop;    // Token is the end-of-packet marker
	logic [7:0] cmd_data;   // Command byte
	logic       rsp_valid;  // Reply byte or end marker offered
	logic       rsp_ready;  // Sender takes it
	logic       rsp_eop;    // Token is the end-of-packet marker
	logic [7:0] rsp_data;   // Reply byte

	modport dev (
		input  clk_sys, arst_n, cmd_valid, cmd_eop, cmd_data, rsp_ready,
		output cmd_ready, rsp_valid, rsp_eop, rsp_data
	);
	modport host (
		input  clk_sys, arst_n, cmd_ready, rsp_valid, rsp_eop, rsp_data,
		output cmd_valid, cmd_eop, cmd_data, rsp_ready
	);
endinterface
`default_nettype wire

//--- hw/rri_pkg.sv
// Shared constants for the read-incrementing command link
package rri_pkg;
	localparam logic [7:0]  CFG_PORT   = 8'h00;        // Configuration port address
	localparam logic [7:0]  LA_DEF     = 8'hFE;        // Default logical address
	localparam logic [7:0]  PROTO_ID   = 8'h01;        // Protocol identifier
	localparam logic [7:0]  KEY_RESET  = 8'h20;        // Key register value after power on
	localparam logic [7:0]  EXT_ADDR   = 8'h00;        // Extended address, unused
	localparam logic [7:0]  RSVD_BYTE  = 8'h00;        // Reserved reply byte
	localparam logic [1:0]  TYPE_CMD   = 2'h1;         // Packet type of a command
	localparam logic [1:0]  TYPE_REPLY = 2'h0;         // Packet type of a reply
	localparam logic [3:0]  CODE_RDINC = 4'h3;         // Read incrementing command code
	localparam logic [23:0] LEN_MIN    = 24'h00_0004;  // Least byte count
	localparam logic [23:0] LEN_MAX    = 24'h00_0428;  // Largest byte count (1064)
	localparam logic [16:0] ADDR_LAST  = 17'h0_0109;   // Top of register address range
	localparam logic [7:0]  CRC_INIT   = 8'h00;        // Check code start value
	localparam logic [7:0]  CRC_POLY   = 8'hE0;        // Reflected x^8+x^2+x+1
	localparam logic [7:0]  ST_OK      = 8'h00;        // Command successful
	localparam logic [7:0]  ST_CMD     = 8'h02;        // Unused type or command code
	localparam logic [7:0]  ST_KEY     = 8'h03;        // Key mismatch
	localparam logic [7:0]  ST_ACCESS  = 8'h0A;        // Length, alignment or range refused
	localparam logic [7:0]  ST_LA      = 8'h0C;        // Wrong target logical address
	localparam logic [4:0]  POS_DLA    = 5'h01;        // Command byte positions
	localparam logic [4:0]  POS_PID    = 5'h02;
	localparam logic [4:0]  POS_CMD    = 5'h03;
	localparam logic [4:0]  POS_KEY    = 5'h04;
	localparam logic [4:0]  POS_PATH   = 5'h05;        // First return-path byte
	localparam logic [4:0]  OFF_SLA    = 5'h00;        // Offsets after the return path
	localparam logic [4:0]  OFF_TIDM   = 5'h01;
	localparam logic [4:0]  OFF_TIDL   = 5'h02;
	localparam logic [4:0]  OFF_EXT    = 5'h03;
	localparam logic [4:0]  OFF_ADDR   = 5'h04;        // Four bytes, MS first
	localparam logic [4:0]  OFF_LEN    = 5'h08;        // Three bytes, MS first
	localparam logic [4:0]  OFF_HCRC   = 5'h0B;
	localparam logic [4:0]  ROFF_SLA   = 5'h00;        // Reply offsets after the path
	localparam logic [4:0]  ROFF_PID   = 5'h01;
	localparam logic [4:0]  ROFF_CMD   = 5'h02;
	localparam logic [4:0]  ROFF_ST    = 5'h03;
	localparam logic [4:0]  ROFF_TLA   = 5'h04;
	localparam logic [4:0]  ROFF_TIDM  = 5'h05;
	localparam logic [4:0]  ROFF_TIDL  = 5'h06;
	localparam logic [4:0]  ROFF_RSVD  = 5'h07;
	localparam logic [4:0]  ROFF_LEN   = 5'h08;        // Three bytes, MS first
	localparam logic [4:0]  ROFF_HCRC  = 5'h0B;
endpackage
